// ==== rtl/hbd_decoder.sv ====
// hbd_decoder: high-band parameter decoding, pulse limiting, energy smoothing
// assumes one 20 MHz clock, synchronous reset, classic wishbone master.
// Functional notes
// (RL1) mode indicator at frame start: <=1 short, 2 medium, 3 long frame.
// (RL2) high-band envelope has eight parameters, for an order-8 synthesis filter.
// (RL3) envelope loss flag comes from the frame's first packet, packet 0 if long.
// (RL4) gain loss vector: one, two or all four packet flags by frame kind.
// (RL5) subframes per frame: 4, 8 or 16, each of 64 samples.
// (RL6) received envelope: stage one plus stage two plus mean plus half memory.
// (RL7) lost envelope: 0.9 times memory plus mean.
// (RL8) reorder envelope to a minimum gap; memory clears on reset.
// (RL9) envelope per subframe interpolated i/nb between previous and new sets.
// (RL10) junction gain per subframe interpolated the same way in dB.
// (RL11) subframe dB gain is estimate plus stage one plus stage two.
// (RL12) seven-bit index gives four gains from codebook plus mean when received.
// (RL13) lost gains decay memory toward -20 dB; memory reloads from gain average.
// (RL14) four stage-one gains spread over 4, 8 or 16 subframes.
// (RL15) short frames use zero stage-two corrections.
// (RL16) medium frames: 3*idx-4.5 dB per subframe, zero when lost.
// (RL17) long frames: 3*idx-10.5 dB per subframe, zero when lost.
// (RL18) linear gain is ten to the dB gain over twenty.
// (RL19) excitation threshold follows a 0.02/(1-0.98z^-1) low-pass; zero at reset.
// (RL20) samples beyond twice the threshold are pulses, clipped to that level.
// (RL21) attenuation is excess over twice threshold; half of it raises threshold.
// (RL22) subframe energy is 0.0001 plus sum of squares; scale by sqrt(t/e).
// (RL23) smoothing threshold moves toward energy, bounded by a 1.414 ratio.
// (RL24) after a frame keep envelope minus mean, envelope and junction gain.
// (RL25) upstream delivers mode, loss flags, indices and excitation beforehand.
`timescale 1ns/10ps
module hbd_decoder #(
  parameter int SUB_LEN = hbd_pkg::SUB_LEN
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  if (SUB_LEN < 2 || SUB_LEN > 64 || (SUB_LEN & (SUB_LEN - 1)) != 0) begin : g_chk
    $error("SUB_LEN must be a power of two up to 64");
  end

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) merge[8*b +: 8] = n[8*b +: 8];
    end
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [19:0] v);
    if (v > 20'sd32767) return 16'sh7fff;
    if (v < -20'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic signed [15:0] q15(input logic signed [15:0] a,
                                             input logic signed [15:0] c);
    logic signed [31:0] p;
    p = a * c;
    return p[30:15];
  endfunction

  // linear step between old and new, i/nb with nb a power of two
  function automatic logic signed [15:0] interp(input logic signed [15:0] old,
      input logic signed [15:0] nw, input logic [3:0] i, input logic [2:0] lg2);
    logic signed [21:0] d;
    logic signed [21:0] f;
    f = {18'h0, i};
    d = (22'(nw) - 22'(old)) * f;
    return 16'(22'(old) + (d >>> lg2));
  endfunction

  // piecewise-linear 2^x; limits result to Q16.16 range
  function automatic logic [31:0] dbToLin(input logic signed [15:0] g);
    logic signed [32:0] p;
    logic signed [7:0] e;
    logic [31:0] m;
    p = g * $signed({1'b0, hbd_pkg::LOG2_10_20});
    e = p[31:24];
    m = {15'h0, 1'b1, p[23:16], 8'h0};
    if (e > 8'sd14) return 32'hffff_ffff;
    if (e < -8'sd16) return 32'h0;
    if (e >= 8'sd0) return m << e[4:0];
    return m >> 5'(-e);
  endfunction

  function automatic hbd_pkg::hbd_frame_t decodeFrame(input logic [13:0] r);
    hbd_pkg::hbd_frame_t f;
    logic [1:0] k;
    logic [1:0] m;
    logic [3:0] b;
    k = r[13:12];
    b = r[11:8];
    m = r[{k, 1'b0} +: 2];
    if (m == 2'h3) begin
      f.kind = hbd_pkg::HBD_LONG; // RL1
      f.lg2 = 3'h4;
      f.envLoss = b[0]; // RL3
      f.gainLoss = b; // RL4
    end else if (m == 2'h2) begin
      f.kind = hbd_pkg::HBD_MED; // RL1
      f.lg2 = 3'h3;
      f.envLoss = b[k]; // RL3
      f.gainLoss = {2'h0, b[2'(k + 2'h1)], b[k]}; // RL4
    end else begin
      f.kind = hbd_pkg::HBD_SHORT; // RL1
      f.lg2 = 3'h2;
      f.envLoss = b[k]; // RL3
      f.gainLoss = {3'h0, b[k]}; // RL4
    end
    f.nb = 5'h1 << f.lg2; // RL5
    return f;
  endfunction

  logic [15:0] tbl [hbd_pkg::TBL_DEPTH];
  function automatic logic signed [15:0] tblS(input logic [10:0] a);
    return $signed(tbl[a]);
  endfunction

  logic req, wr, rd;
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i;
  assign rd = req & ~we_i;

  // software registers
  logic [31:0] mode_q, idx_q, c2Lo_q, c2Hi_q, jg_q, subSel_q;
  logic [10:0] tblAddr_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q <= hbd_pkg::REG_RST;
      idx_q <= hbd_pkg::REG_RST;
      c2Lo_q <= hbd_pkg::REG_RST;
      c2Hi_q <= hbd_pkg::REG_RST;
      jg_q <= hbd_pkg::REG_RST;
      subSel_q <= hbd_pkg::REG_RST;
      tblAddr_q <= hbd_pkg::REG_RST[10:0];
    end else if (wr) begin
      case (adr_i)
        hbd_pkg::OFF_MODE: mode_q <= merge(mode_q, dat_i, sel_i);
        hbd_pkg::OFF_IDX: idx_q <= merge(idx_q, dat_i, sel_i);
        hbd_pkg::OFF_C2LO: c2Lo_q <= merge(c2Lo_q, dat_i, sel_i);
        hbd_pkg::OFF_C2HI: c2Hi_q <= merge(c2Hi_q, dat_i, sel_i);
        hbd_pkg::OFF_JGAIN: jg_q <= merge(jg_q, dat_i, sel_i);
        hbd_pkg::OFF_SUBSEL: subSel_q <= merge(subSel_q, dat_i, sel_i);
        hbd_pkg::OFF_TBLADR: tblAddr_q <= dat_i[10:0];
        hbd_pkg::OFF_TBLDAT: tblAddr_q <= tblAddr_q + 11'h1;
        default: ;
      endcase
    end
  end

  // codebooks and means are loaded by software, no reset
  always_ff @(posedge clk_sys) begin
    if (wr && adr_i == hbd_pkg::OFF_TBLDAT) tbl[tblAddr_q] <= dat_i[15:0];
  end

  // frame decode sequencer
  hbd_pkg::hbd_state_t st_q;
  hbd_pkg::hbd_frame_t frm_q, frmNow;
  logic [2:0] ordCnt_q;
  logic signed [15:0] envCur_q [8];
  logic signed [15:0] envPrev_q [8];
  logic signed [15:0] envMem_q [8];
  logic signed [15:0] jgCur_q, jgPrev_q;
  logic signed [16:0] ordLo;
  logic startReq;
  assign frmNow = decodeFrame(mode_q[13:0]);
  assign startReq = wr && adr_i == hbd_pkg::OFF_CTRL && dat_i[0] && st_q == hbd_pkg::ST_IDLE;
  assign ordLo = (ordCnt_q == 3'h0) ? 17'(hbd_pkg::ENV_GAP)
               : 17'(envCur_q[3'(ordCnt_q - 3'h1)]) + 17'(hbd_pkg::ENV_GAP);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= hbd_pkg::ST_IDLE;
      ordCnt_q <= 3'h0;
      frm_q <= '0;
      jgCur_q <= 16'sh0;
      jgPrev_q <= 16'sh0;
      for (int j = 0; j < hbd_pkg::ENV_ORDER; j++) begin
        envCur_q[j] <= 16'sh0;
        envPrev_q[j] <= 16'sh0;
        envMem_q[j] <= 16'sh0; // RL8
      end
    end else begin
      unique case (st_q)
        hbd_pkg::ST_IDLE: if (startReq) begin
          frm_q <= frmNow;
          jgPrev_q <= jgCur_q; // RL24
          jgCur_q <= jg_q[15:0];
          st_q <= hbd_pkg::ST_ENV;
        end
        hbd_pkg::ST_ENV: begin
          for (int j = 0; j < hbd_pkg::ENV_ORDER; j++) begin // RL2
            envPrev_q[j] <= envCur_q[j]; // RL24
            if (frm_q.envLoss) begin
              envCur_q[j] <= sat16(20'(q15(envMem_q[j], hbd_pkg::Q15_0P9))
                + 20'(tblS(hbd_pkg::TBL_MEAN + 11'(j)))); // RL7
            end else begin
              envCur_q[j] <= sat16(20'(tblS(hbd_pkg::TBL_CB1 + 11'({idx_q[1:0], 3'(j)})))
                + 20'(tblS(hbd_pkg::TBL_CB2 + 11'({idx_q[14:8], 3'(j)})))
                + 20'(tblS(hbd_pkg::TBL_MEAN + 11'(j)))
                + 20'(envMem_q[j] >>> 1)); // RL6
            end
          end
          ordCnt_q <= 3'h0;
          st_q <= hbd_pkg::ST_ORDER;
        end
        hbd_pkg::ST_ORDER: begin
          // one element a cycle so each sees its corrected neighbour
          if (17'(envCur_q[ordCnt_q]) < ordLo) envCur_q[ordCnt_q] <= sat16(20'(ordLo)); // RL8
          ordCnt_q <= ordCnt_q + 3'h1;
          if (ordCnt_q == 3'h7) st_q <= hbd_pkg::ST_GAIN;
        end
        hbd_pkg::ST_GAIN: st_q <= hbd_pkg::ST_GMEM;
        hbd_pkg::ST_GMEM: begin
          for (int j = 0; j < hbd_pkg::ENV_ORDER; j++) begin
            envMem_q[j] <= sat16(20'(envCur_q[j]) - 20'(tblS(hbd_pkg::TBL_MEAN + 11'(j)))); // RL24
          end
          st_q <= hbd_pkg::ST_IDLE;
        end
        default: st_q <= hbd_pkg::ST_IDLE;
      endcase
    end
  end

  // stage-one gains
  logic signed [15:0] gain_q [4];
  logic signed [15:0] gMem_q, gMean, gLossMem;
  logic signed [19:0] gSum;
  assign gMean = tblS(hbd_pkg::TBL_GMEAN);
  assign gLossMem = sat16(20'(q15(sat16(20'(gMem_q) + 20'(hbd_pkg::DB_20)), hbd_pkg::Q15_0P9))
                  - 20'(hbd_pkg::DB_20));
  assign gSum = 20'(gain_q[0]) + 20'(gain_q[1]) + 20'(gain_q[2]) + 20'(gain_q[3]);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gMem_q <= 16'sh0;
      for (int k = 0; k < 4; k++) gain_q[k] <= 16'sh0;
    end else if (st_q == hbd_pkg::ST_GAIN) begin
      for (int k = 0; k < 4; k++) begin
        if (!frm_q.gainLoss[0]) begin
          gain_q[k] <= sat16(20'(tblS(hbd_pkg::TBL_GCB + 11'({idx_q[22:16], 2'(k)})))
                     + 20'(gMean)); // RL12
        end else begin
          gain_q[k] <= sat16(20'(gLossMem) + 20'(gMean)); // RL13
        end
      end
      if (frm_q.gainLoss[0]) gMem_q <= gLossMem; // RL13
    end else if (st_q == hbd_pkg::ST_GMEM) begin
      gMem_q <= sat16((gSum >>> 2) - 20'(gMean)); // RL13
    end
  end

  // per-subframe views selected by software
  logic [3:0] sI;
  logic [2:0] sJ;
  logic [47:0] c2Bits;
  logic [1:0] c2M;
  logic [2:0] c2L;
  logic signed [15:0] subEnv, c2, subDb;
  logic [31:0] subLin;
  assign sI = subSel_q[3:0];
  assign sJ = subSel_q[6:4];
  assign c2Bits = {c2Hi_q[15:0], c2Lo_q};
  assign c2M = c2Bits[{sI, 1'b0} +: 2];
  // widen before the product: i*3 reaches 45 on long frames
  assign c2L = c2Bits[6'(sI) * 6'h3 +: 3];
  assign subEnv = interp(envPrev_q[sJ], envCur_q[sJ], sI, frm_q.lg2); // RL9
  always_comb begin
    c2 = 16'sh0; // RL15
    if (!frm_q.gainLoss[0]) begin
      if (frm_q.kind == hbd_pkg::HBD_MED) c2 = 16'(hbd_pkg::DB_STEP * 16'(c2M)) - hbd_pkg::DB_C2M; // RL16
      if (frm_q.kind == hbd_pkg::HBD_LONG) c2 = 16'(hbd_pkg::DB_STEP * 16'(c2L)) - hbd_pkg::DB_C2L; // RL17
    end
  end
  assign subDb = sat16(20'(interp(jgPrev_q, jgCur_q, sI, frm_q.lg2)) // RL10
               + 20'(gain_q[2'(sI >> (frm_q.lg2 - 3'h2))]) // RL14
               + 20'(c2)); // RL11
  assign subLin = dbToLin(subDb); // RL18

  // excitation pulse limiting
  logic [23:0] thres_q;
  logic signed [15:0] excOut_q, excX, excY;
  logic [24:0] ax8, th2, delta;
  logic signed [37:0] thStep;
  logic [23:0] th1, thNew;
  logic excWr;
  assign excWr = wr && adr_i == hbd_pkg::OFF_EXC;
  assign excX = dat_i[15:0];
  always_comb begin
    ax8 = {1'b0, (excX < 16'sh0) ? 16'(-excX) : excX, 8'h0};
    thStep = (38'(ax8) - 38'(thres_q)) * $signed({26'h0, hbd_pkg::TH_ALPHA});
    th1 = 24'(38'(thres_q) + (thStep >>> 16)); // RL19
    th2 = {th1, 1'b0};
    delta = (ax8 > th2) ? ax8 - th2 : 25'h0; // RL21
    thNew = th1 + delta[24:1]; // RL21
    excY = (excX >= 16'sh0) ? excX - 16'(delta[24:8]) : excX + 16'(delta[24:8]); // RL20
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      thres_q <= hbd_pkg::THRES_RST; // RL19
      excOut_q <= 16'sh0;
    end else if (excWr) begin
      thres_q <= thNew;
      excOut_q <= excY;
    end
  end
  exc_limit_a: assert property (@(posedge clk_sys) disable iff (rst) // RL20
    excWr |=> $signed({8'h0, excOut_q < 0 ? -excOut_q : excOut_q, 8'h0})
              <= $signed({8'h0, $past(th2)}) + 32'sh100)
    else $error("excitation not clipped to twice threshold");
  thres_rst_a: assert property (@(posedge clk_sys) $past(rst) |-> thres_q == 24'h0) // RL19
    else $error("threshold not cleared by reset");

  // synthesis energy smoothing
  hbd_pkg::hbd_syn_t syn_q;
  logic signed [15:0] synBuf [64];
  logic [6:0] synCnt_q;
  logic [39:0] energy_q, tsm_q, eTot, tUp, tDn, newT;
  logic [40:0] rem_q;
  logic [15:0] quo_q;
  logic [16:0] scale;
  logic signed [33:0] prod;
  logic signed [15:0] synY, synX;
  logic signed [31:0] sq;
  logic synWr, synRd, ge;
  assign synX = dat_i[15:0];
  assign synWr = wr && adr_i == hbd_pkg::OFF_SYN && syn_q == hbd_pkg::SY_FILL;
  assign synRd = rd && adr_i == hbd_pkg::OFF_SYN && syn_q == hbd_pkg::SY_DRAIN;
  assign sq = synX * synX;
  assign eTot = energy_q + hbd_pkg::EN_EPS; // RL22
  assign tUp = 40'((56'(eTot) * 56'(hbd_pkg::SM_UP)) >> 14);
  assign tDn = 40'((56'(eTot) * 56'(hbd_pkg::SM_DN)) >> 14);
  assign newT = (eTot < tsm_q) ? ((tUp < tsm_q) ? tUp : tsm_q)
                               : ((tDn > tsm_q) ? tDn : tsm_q); // RL23
  assign ge = rem_q >= {1'b0, energy_q};
  // sqrt(r) taken as (1+r)/2: r stays within 0.707..1.414, error under 2 %
  assign scale = 17'h4000 + 17'(quo_q >> 1); // RL22
  assign prod = synBuf[synCnt_q[5:0]] * $signed({1'b0, scale});
  assign synY = sat16(20'(prod >>> 15)); // RL22
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syn_q <= hbd_pkg::SY_FILL;
      synCnt_q <= 7'h0;
      energy_q <= 40'h0;
      tsm_q <= hbd_pkg::TSM_RST; // RL23
      rem_q <= 41'h0;
      quo_q <= 16'h0;
    end else begin
      unique case (syn_q)
        hbd_pkg::SY_FILL: if (synWr) begin
          synBuf[synCnt_q[5:0]] <= synX;
          energy_q <= energy_q + 40'($unsigned(sq)); // RL22
          synCnt_q <= synCnt_q + 7'h1;
          if (synCnt_q == 7'(SUB_LEN - 1)) syn_q <= hbd_pkg::SY_THR;
        end
        hbd_pkg::SY_THR: begin
          energy_q <= eTot;
          tsm_q <= newT; // RL23
          rem_q <= {1'b0, newT};
          quo_q <= 16'h0;
          synCnt_q <= 7'h0;
          syn_q <= hbd_pkg::SY_DIV;
        end
        hbd_pkg::SY_DIV: begin
          quo_q <= {quo_q[14:0], ge}; // RL22
          rem_q <= 41'((ge ? rem_q - {1'b0, energy_q} : rem_q) << 1);
          synCnt_q <= (synCnt_q == hbd_pkg::DIV_LAST) ? 7'h0 : synCnt_q + 7'h1;
          if (synCnt_q == hbd_pkg::DIV_LAST) syn_q <= hbd_pkg::SY_DRAIN;
        end
        hbd_pkg::SY_DRAIN: if (synRd) begin
          synCnt_q <= synCnt_q + 7'h1;
          if (synCnt_q == 7'(SUB_LEN - 1)) begin
            synCnt_q <= 7'h0;
            energy_q <= 40'h0;
            syn_q <= hbd_pkg::SY_FILL;
          end
        end
        default: syn_q <= hbd_pkg::SY_FILL;
      endcase
    end
  end
  div_time_a: assert property (@(posedge clk_sys) disable iff (rst) // RL22
    syn_q == hbd_pkg::SY_THR |=> syn_q == hbd_pkg::SY_DIV
      ##15 (syn_q == hbd_pkg::SY_DIV && synCnt_q == hbd_pkg::DIV_LAST)
      ##1 syn_q == hbd_pkg::SY_DRAIN)
    else $error("divider did not take sixteen cycles");
  tsm_band_a: assert property (@(posedge clk_sys) disable iff (rst) // RL23
    syn_q == hbd_pkg::SY_DIV |-> quo_q <= 16'hb506)
    else $error("smoothing ratio beyond bound");

  // wishbone answer, one cycle after request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req;
      if (rd) begin
        case (adr_i)
          hbd_pkg::OFF_CTRL: dat_o <= {31'h0, st_q != hbd_pkg::ST_IDLE};
          hbd_pkg::OFF_MODE: dat_o <= mode_q;
          hbd_pkg::OFF_STATUS: dat_o <= {14'h0, syn_q, frm_q, st_q != hbd_pkg::ST_IDLE};
          hbd_pkg::OFF_IDX: dat_o <= idx_q;
          hbd_pkg::OFF_C2LO: dat_o <= c2Lo_q;
          hbd_pkg::OFF_C2HI: dat_o <= c2Hi_q;
          hbd_pkg::OFF_JGAIN: dat_o <= jg_q;
          hbd_pkg::OFF_SUBSEL: dat_o <= subSel_q;
          hbd_pkg::OFF_SUBENV: dat_o <= {{16{subEnv[15]}}, subEnv};
          hbd_pkg::OFF_SUBGAIN: dat_o <= subLin;
          hbd_pkg::OFF_TBLADR: dat_o <= {21'h0, tblAddr_q};
          hbd_pkg::OFF_EXC: dat_o <= {{16{excOut_q[15]}}, excOut_q};
          hbd_pkg::OFF_THRES: dat_o <= {8'h0, thres_q};
          hbd_pkg::OFF_SYN: dat_o <= synRd ? {{16{synY[15]}}, synY} : 32'h0;
          hbd_pkg::OFF_TSM: dat_o <= tsm_q[39:8];
          default: dat_o <= 32'h0;
        endcase
      end
    end
  end
  ack_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  frame_len_a: assert property (@(posedge clk_sys) disable iff (rst) // RL5
    startReq |-> ##12 st_q == hbd_pkg::ST_IDLE && $past(st_q) == hbd_pkg::ST_GMEM)
    else $error("frame decode did not finish in twelve cycles");
  long_map_a: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    frmNow.kind == hbd_pkg::HBD_LONG |-> frmNow.nb == 5'h10 && frmNow.envLoss == mode_q[8])
    else $error("long frame mapping wrong");
  gain_loss_a: assert property (@(posedge clk_sys) disable iff (rst) // RL13
    st_q == hbd_pkg::ST_GAIN && frm_q.gainLoss[0] |=> gain_q[0] == gain_q[3])
    else $error("lost gains not equal");
  env_gap_a: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    st_q == hbd_pkg::ST_GAIN |-> 17'(envCur_q[1]) >= 17'(envCur_q[0]) + 17'(hbd_pkg::ENV_GAP)
      || envCur_q[1] == 16'sh7fff)
    else $error("envelope gap not kept");
endmodule

// ==== shared/hbd_pkg.sv ====
// hbd_pkg: register map, table layout, fixed-point constants and types
// for the high-band decoder; assumes a 32-bit classic wishbone host.
package hbd_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IDX = 8'h0c;
  localparam logic [7:0] OFF_C2LO = 8'h10;
  localparam logic [7:0] OFF_C2HI = 8'h14;
  localparam logic [7:0] OFF_JGAIN = 8'h18;
  localparam logic [7:0] OFF_SUBSEL = 8'h1c;
  localparam logic [7:0] OFF_SUBENV = 8'h20;
  localparam logic [7:0] OFF_SUBGAIN = 8'h24;
  localparam logic [7:0] OFF_TBLADR = 8'h28;
  localparam logic [7:0] OFF_TBLDAT = 8'h2c;
  localparam logic [7:0] OFF_EXC = 8'h30;
  localparam logic [7:0] OFF_THRES = 8'h34;
  localparam logic [7:0] OFF_SYN = 8'h38;
  localparam logic [7:0] OFF_TSM = 8'h3c;
  localparam logic [31:0] REG_RST = 32'h0;
  // coefficient table layout (16-bit words)
  localparam int TBL_DEPTH = 2048;
  localparam logic [10:0] TBL_CB1 = 11'h000;
  localparam logic [10:0] TBL_CB2 = 11'h020;
  localparam logic [10:0] TBL_GCB = 11'h420;
  localparam logic [10:0] TBL_MEAN = 11'h620;
  localparam logic [10:0] TBL_GMEAN = 11'h628;
  // envelope: full scale 32768 stands for fs/2
  localparam int ENV_ORDER = 8;
  localparam int FS_HALF = 32768;
  localparam logic signed [15:0] ENV_GAP = 16'(9 * 2 * FS_HALF / 1280);
  localparam logic signed [15:0] Q15_0P9 = 16'sh7333;
  // gains in dB, Q8.8
  localparam logic signed [15:0] DB_20 = 16'sh1400;
  localparam logic signed [15:0] DB_STEP = 16'sh0300;
  localparam logic signed [15:0] DB_C2M = 16'sh0480;
  localparam logic signed [15:0] DB_C2L = 16'sh0a80;
  localparam logic [15:0] LOG2_10_20 = 16'h2a85;
  // excitation threshold Q16.8, low-pass weight Q0.16
  localparam logic [11:0] TH_ALPHA = 12'h51f;
  localparam logic [23:0] THRES_RST = 24'h0;
  // smoothing: samples Q15, energy Q30
  localparam logic [39:0] EN_EPS = 40'h1a36e;
  localparam logic [15:0] SM_UP = 16'h5a7f;
  localparam logic [15:0] SM_DN = 16'h2d43;
  localparam logic [39:0] TSM_RST = 40'h0;
  localparam int SUB_LEN = 64;
  localparam logic [6:0] DIV_LAST = 7'h0f;
  typedef enum logic [1:0] {HBD_SHORT = 2'h1, HBD_MED = 2'h2, HBD_LONG = 2'h3} hbd_kind_t;
  typedef struct packed {
    hbd_kind_t kind;
    logic [4:0] nb;
    logic [2:0] lg2;
    logic envLoss;
    logic [3:0] gainLoss;
  } hbd_frame_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ENV = 3'h1, ST_ORDER = 3'h2, ST_GAIN = 3'h3, ST_GMEM = 3'h4
  } hbd_state_t;
  typedef enum logic [1:0] {SY_FILL = 2'h0, SY_THR = 2'h1, SY_DIV = 2'h2, SY_DRAIN = 2'h3} hbd_syn_t;
endpackage

// ==== bench/hbd_upstream_model.sv ====
// hbd_upstream_model: stands in for the demultiplexer and low-band core
// assumes the bench copies its word into the decoder's mode register.
`timescale 1ns/10ps
module hbd_upstream_model (
  // frame choice
  input wire logic [1:0] frameSel,
  // {start packet, loss flags, four indicators}
  output logic [13:0] modeWord
);
  // word is ready before any start request is made
  always_comb begin
    case (frameSel)
      2'h0: modeWord = {2'h1, 4'h2, 8'h00};
      2'h1: modeWord = {2'h2, 4'h8, 8'haa};
      2'h2: modeWord = {2'h0, 4'h1, 8'hff};
      default: modeWord = {2'h3, 4'h0, 8'h55};
    endcase
  end
endmodule

// ==== bench/hbd_decoder_tb.sv ====
// hbd_decoder_tb: scenarios for the high-band decoder over wishbone
// assumes a 4-sample subframe and a table holding zero means.
`timescale 1ns/10ps
module hbd_decoder_tb;
  localparam int SUB = 4;
  logic clk_sys, rst, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [1:0] frameSel;
  logic [13:0] modeWord;
  int failures, compares, cycles;
  hbd_decoder #(.SUB_LEN(SUB)) i_dut (.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat), .ack_o(ack));
  hbd_upstream_model i_up (.frameSel(frameSel), .modeWord(modeWord));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input logic [31:0] got, input logic [31:0] exp, input int tol);
    logic [31:0] d;
    d = (got > exp) ? got - exp : exp - got;
    compares++;
    if ((d <= tol) !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // zero a table range so no decode ever reads an unknown word
  task automatic tload(input logic [10:0] base, input int n);
    wb(1'b1, hbd_pkg::OFF_TBLADR, {21'h0, base}, q);
    repeat (n) wb(1'b1, hbd_pkg::OFF_TBLDAT, 32'h0, q);
  endtask
  task automatic waitIdle();
    do wb(1'b0, hbd_pkg::OFF_CTRL, 32'h0, q); while (q[0] !== 1'b0);
  endtask
  task automatic t_reset();
    wb(1'b0, hbd_pkg::OFF_THRES, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, hbd_pkg::OFF_TSM, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_kinds();
    logic [14:0] exp [4];
    exp = '{{2'h1, 5'h04, 3'h0, 1'b1, 4'h1}, {2'h2, 5'h08, 3'h0, 1'b0, 4'h2},
            {2'h3, 5'h10, 3'h0, 1'b1, 4'h1}, {2'h1, 5'h04, 3'h0, 1'b0, 4'h0}};
    for (int f = 0; f < 4; f++) begin
      frameSel <= f[1:0];
      @(posedge clk_sys);
      wb(1'b1, hbd_pkg::OFF_MODE, {18'h0, modeWord}, q);
      wb(1'b1, hbd_pkg::OFF_CTRL, 32'h1, q);
      wb(1'b0, hbd_pkg::OFF_STATUS, 32'h0, q);
      chk({31'h0, q[0]}, 32'h1);
      waitIdle();
      wb(1'b0, hbd_pkg::OFF_STATUS, 32'h0, q);
      chk({17'h0, q[15:1] & 15'h7f1f}, {17'h0, exp[f]});
    end
    $display("frame kind test done");
  endtask
  task automatic t_conceal();
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wb(1'b1, hbd_pkg::OFF_TBLADR, {21'h0, hbd_pkg::TBL_MEAN}, q);
    repeat (9) wb(1'b1, hbd_pkg::OFF_TBLDAT, 32'h0, q);
    wb(1'b1, hbd_pkg::OFF_MODE, 32'h00000f00, q);
    repeat (2) begin
      wb(1'b1, hbd_pkg::OFF_CTRL, 32'h1, q);
      waitIdle();
    end
    wb(1'b1, hbd_pkg::OFF_SUBSEL, 32'h03, q);
    wb(1'b0, hbd_pkg::OFF_SUBENV, 32'h0, q);
    chk(q, 32'd460);
    wb(1'b1, hbd_pkg::OFF_SUBSEL, 32'h73, q);
    wb(1'b0, hbd_pkg::OFF_SUBENV, 32'h0, q);
    chk(q, 32'd3680);
    wb(1'b1, hbd_pkg::OFF_SUBSEL, 32'h0, q);
    wb(1'b0, hbd_pkg::OFF_SUBGAIN, 32'h0, q);
    near(q, 32'd42317, 3000);
    $display("concealment test done");
  endtask
  task automatic t_pulse();
    wb(1'b1, hbd_pkg::OFF_EXC, 32'h1000, q);
    wb(1'b0, hbd_pkg::OFF_EXC, 32'h0, q);
    near({16'h0, q[15:0]}, 32'd164, 1);
    wb(1'b0, hbd_pkg::OFF_THRES, 32'h0, q);
    near(q, 32'd524288, 4);
    wb(1'b1, hbd_pkg::OFF_EXC, 32'hf000, q);
    wb(1'b0, hbd_pkg::OFF_EXC, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'hf000);
    wb(1'b0, hbd_pkg::OFF_THRES, 32'h0, q);
    near(q, 32'd534776, 8);
    $display("pulse test done");
  endtask
  // received gains, stage-two index 3 on long i=1 and 1 on medium i=2: -1.5 dB
  task automatic t_recv();
    wb(1'b1, hbd_pkg::OFF_IDX, 32'h0, q);
    wb(1'b1, hbd_pkg::OFF_C2LO, 32'h18, q);
    wb(1'b1, hbd_pkg::OFF_SUBSEL, 32'h1, q);
    wb(1'b1, hbd_pkg::OFF_MODE, 32'h000000ff, q);
    wb(1'b1, hbd_pkg::OFF_CTRL, 32'h1, q);
    waitIdle();
    wb(1'b0, hbd_pkg::OFF_SUBGAIN, 32'h0, q);
    near(q, 32'd55142, 3000);
    wb(1'b1, hbd_pkg::OFF_MODE, 32'h0000000a, q);
    wb(1'b1, hbd_pkg::OFF_SUBSEL, 32'h2, q);
    wb(1'b1, hbd_pkg::OFF_CTRL, 32'h1, q);
    waitIdle();
    wb(1'b0, hbd_pkg::OFF_SUBGAIN, 32'h0, q);
    near(q, 32'd55142, 3000);
    $display("received gain test done");
  endtask
  task automatic t_smooth();
    wb(1'b0, hbd_pkg::OFF_SYN, 32'h0, q);
    chk(q, 32'h0);
    repeat (SUB) wb(1'b1, hbd_pkg::OFF_SYN, 32'h4000, q);
    do wb(1'b0, hbd_pkg::OFF_STATUS, 32'h0, q); while (q[17:16] !== 2'h3);
    repeat (SUB) begin
      wb(1'b0, hbd_pkg::OFF_SYN, 32'h0, q);
      near(q, 32'd13880, 300);
    end
    wb(1'b0, hbd_pkg::OFF_STATUS, 32'h0, q);
    chk({30'h0, q[17:16]}, 32'h0);
    $display("smoothing test done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_sys);
      cycles++;
      if (cycles == 20000) begin
        failures++;
        stop_test();
      end
    end
  end
  initial begin
    failures = 0;
    compares = 0;
    frameSel = 2'h0;
    rst = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h0;
    dat = 32'h0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    tload(hbd_pkg::TBL_CB1, 40);
    tload(hbd_pkg::TBL_GCB, 4);
    tload(hbd_pkg::TBL_MEAN, 9);
    t_kinds();
    t_conceal();
    t_pulse();
    t_recv();
    t_smooth();
    stop_test();
  end
endmodule
